// ### hdl/cfb_pkg.sv
// Package with register map, field layout and constants for the CAN fault and bit timing block
package cfb_pkg;
  // Register byte offsets (Avalon word aligned)
  localparam logic [3:0] OFS_ERR_PAIR = 4'h0;
  localparam logic [3:0] OFS_STATE = 4'h4;
  localparam logic [3:0] OFS_TIMING = 4'h8;
  localparam logic [3:0] OFS_CTRL = 4'hC;
  // Timing register fields
  localparam int TIM_T1_LSB = 0;
  localparam int TIM_T2_LSB = 4;
  localparam int TIM_SJW_LSB = 8;
  localparam int TIM_PSC_LSB = 16;
  localparam logic [31:0] TIM_RESET = 32'h0001_0243;
  // Fault confinement thresholds and counter step
  localparam logic [8:0] WARN_LIMIT = 9'h060;
  localparam logic [8:0] PASSIVE_LIMIT = 9'h07F;
  localparam logic [8:0] BUSOFF_LIMIT = 9'h0FF;
  localparam logic [3:0] RECESSIVE_RUN = 4'hB;
  localparam logic [7:0] RECOVERY_RUNS = 8'h80;
  localparam logic [3:0] FIRST_DOM_ACTIVE = 4'hE;
  localparam logic [3:0] FIRST_DOM_PASSIVE = 4'h8;
  localparam logic [3:0] DOM_REPEAT = 4'h8;
  localparam logic [7:0] BIG_STEP = 8'h08;

  typedef enum logic [2:0] {
    ST_SYNC = 3'b000,
    ST_ACTIVE = 3'b001,
    ST_WARNING = 3'b010,
    ST_PASSIVE = 3'b011,
    ST_BUSOFF = 3'b100
  } cfb_state_e;

  typedef enum logic [1:0] {
    SEG_SYNC = 2'b00,
    SEG_ONE = 2'b01,
    SEG_TWO = 2'b10
  } cfb_seg_e;
endpackage

// ### hdl/cfb_timing_if.sv
// Interface carrying bit timing configuration and strobes between the modules
`timescale 1ns/1ps
interface cfb_timing_if;
  logic [3:0] firstTimeSegment;
  logic [3:0] secondTimeSegment;
  logic [3:0] resyncJumpWidth;
  logic [15:0] quantumPrescaler;
  logic busOff;
  logic rxSync;
  logic samplePulse;
  logic sampleBit;
  logic txPointPulse;
  modport unit(input firstTimeSegment, secondTimeSegment, resyncJumpWidth, quantumPrescaler,
               input busOff, rxSync, output samplePulse, sampleBit, txPointPulse);
  modport ctrl(output firstTimeSegment, secondTimeSegment, resyncJumpWidth, quantumPrescaler,
               output busOff, rxSync, input samplePulse, sampleBit, txPointPulse);
endinterface

// ### hdl/cfb_bit_timing_unit.sv
// Bit timing unit: quantum prescaler, segment counter, resync and sample point
`timescale 1ns/1ps
module cfb_bit_timing_unit (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Timing link
  cfb_timing_if.unit tif
);
  typedef struct packed {
    logic [15:0] quantum_prescaler;
    logic [4:0] tq;
    logic [4:0] t1Len;
    cfb_pkg::cfb_seg_e seg;
    logic prevBit;
    logic resyncDone;
    logic samp;
    logic sampBit;
    logic txPt;
  } cfb_btu_s;

  cfb_btu_s st_r, st_nxt;
  logic tqEn;
  logic [4:0] t1Cfg, t2Cfg, resync_jump_width;
  logic edgeFall;
  logic [4:0] phaseErr;

  always_comb begin
    st_nxt = st_r;
    st_nxt.samp = 1'b0;
    st_nxt.txPt = 1'b0;
    // Zero prescaler treated as one, so the quantum never stalls
    tqEn = (tif.quantumPrescaler == 16'h0000) ||
           (st_r.quantum_prescaler + 16'h0001 >= tif.quantumPrescaler);
    t1Cfg = (tif.firstTimeSegment == 4'h0) ? 5'h01 : {1'b0, tif.firstTimeSegment};
    t2Cfg = (tif.secondTimeSegment == 4'h0) ? 5'h01 : {1'b0, tif.secondTimeSegment};
    resync_jump_width = {1'b0, tif.resyncJumpWidth};
    edgeFall = st_r.prevBit && !tif.rxSync;
    phaseErr = st_r.tq;
    st_nxt.quantum_prescaler = tqEn ? 16'h0000 : st_r.quantum_prescaler + 16'h0001;
    if (tqEn) begin
      st_nxt.prevBit = tif.rxSync;
      st_nxt.tq = st_r.tq + 5'h01;
      if (edgeFall && !st_r.resyncDone && st_r.seg != cfb_pkg::SEG_SYNC) begin
        st_nxt.resyncDone = 1'b1;
        if (st_r.seg == cfb_pkg::SEG_ONE) begin
          // Late edge: lengthen segment one, capped at jump width
          st_nxt.t1Len = st_r.t1Len + ((phaseErr > resync_jump_width) ? resync_jump_width : phaseErr);
        end else if (st_r.tq + resync_jump_width + 5'h01 >= t2Cfg) begin
          // Early edge within jump width acts as hard sync
          st_nxt.seg = cfb_pkg::SEG_ONE;
          st_nxt.tq = 5'h00;
          st_nxt.t1Len = t1Cfg;
          st_nxt.txPt = 1'b1;
        end else begin
          // Early beyond jump width: cut segment two by jump width
          st_nxt.tq = st_r.tq + resync_jump_width + 5'h01;
        end
      end
      case (st_r.seg)
        cfb_pkg::SEG_SYNC: begin
          st_nxt.seg = cfb_pkg::SEG_ONE;
          st_nxt.tq = 5'h00;
          st_nxt.t1Len = t1Cfg;
          st_nxt.resyncDone = 1'b0;
        end
        cfb_pkg::SEG_ONE: begin
          if (st_r.tq + 5'h01 >= st_nxt.t1Len && st_nxt.seg == cfb_pkg::SEG_ONE &&
              !(edgeFall && !st_r.resyncDone)) begin
            st_nxt.seg = cfb_pkg::SEG_TWO;
            st_nxt.tq = 5'h00;
            st_nxt.samp = 1'b1;
            st_nxt.sampBit = tif.rxSync;
          end
        end
        cfb_pkg::SEG_TWO: begin
          if (st_nxt.seg == cfb_pkg::SEG_TWO && st_nxt.tq >= t2Cfg) begin
            st_nxt.seg = cfb_pkg::SEG_SYNC;
            st_nxt.tq = 5'h00;
            st_nxt.txPt = 1'b1;
          end
        end
        default: st_nxt.seg = cfb_pkg::SEG_SYNC;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '{quantum_prescaler: 16'h0000, tq: 5'h00, t1Len: 5'h01, seg: cfb_pkg::SEG_SYNC,
                prevBit: 1'b1, resyncDone: 1'b0, samp: 1'b0, sampBit: 1'b1, txPt: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tif.samplePulse = st_r.samp;
  assign tif.sampleBit = st_r.sampBit;
  assign tif.txPointPulse = st_r.txPt;
endmodule

// ### hdl/cfb_fault_confinement.sv
// Top: fault confinement counters, node state and Avalon register slave
`timescale 1ns/1ps
// What this block does
// - Leave warning once both counters below 96
// - Passive when either counter exceeds 127
// - Passive node sends only recessive error flag
// - Passive leaves when both below 128, to warning if either is 96 or more
// - Bus off when transmit counter exceeds 255
// - Bus off disables drivers, no bus activity
// - Recover after 128 runs of 11 recessive
// - Clear both counters on bus-off recovery
// - Counters packed into one readable 16-bit register
// - Receive counter stops incrementing at bit 7
// - Receiver flag bit error adds eight
// - Dominant run after flag adds eight repeatedly
// - Transmitter errors add eight
// - Valid frame decrements counter, floor zero
// - Arbitration stuff and passive ack exempt
// - Lone transmitter ack errors never reach bus off
// - Bit splits into sync, first, second segments
// - Sample between segments, transmit at end
// - Segment lengths from own 4-bit fields
// - Resync adjusts bit by at most jump width
// - Wait 11 recessive bits after enable
// - Late edge lengthens, early edge shortens by width
// - Quantum clock from programmable prescaler
module cfb_fault_confinement (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // CAN bus pins
  input wire logic canRx,
  output logic canTx,
  output logic canTxEn,
  // Protocol engine events
  input wire logic errFlagReq,
  input wire logic flagDominant,
  input wire logic isTransmitter,
  input wire logic evRxFlagBitErr,
  input wire logic evRxDomAfterFlag,
  input wire logic evTxFlagBitErr,
  input wire logic evOtherErr,
  input wire logic evArbStuffErr,
  input wire logic evAckErr,
  input wire logic evFlagEnd,
  input wire logic flagWasPassive,
  input wire logic evRxOk,
  input wire logic evTxOk,
  // Node status and bit strobes
  output logic [2:0] nodeState,
  output logic samplePulse,
  output logic sampleBit,
  output logic txPoint
);
  typedef struct packed {
    logic rx1;
    logic rx2;
    logic [7:0] rx_error_count;
    logic [7:0] tx_error_count;
    cfb_pkg::cfb_state_e state;
    logic [3:0] recRun;
    logic [7:0] runCnt;
    logic watchDom;
    logic [3:0] domCnt;
    logic domFirstDone;
    logic domPassiveRule;
    logic passiveSawDom;
    logic [31:0] timing;
    logic enable;
    logic [31:0] rdata;
    logic wait_n;
    logic tx;
    logic txEn;
    logic samp;
    logic sampB;
    logic txPt;
  } cfb_top_s;

  cfb_top_s s_r, s_nxt;
  cfb_timing_if tif();
  logic [8:0] recSum, tecSum;
  logic recBig, recOne, tecBig, tecDec, recDec;
  logic stepDom;
  logic access;

  assign tif.firstTimeSegment = s_r.timing[cfb_pkg::TIM_T1_LSB +: 4];
  assign tif.secondTimeSegment = s_r.timing[cfb_pkg::TIM_T2_LSB +: 4];
  assign tif.resyncJumpWidth = s_r.timing[cfb_pkg::TIM_SJW_LSB +: 4];
  assign tif.quantumPrescaler = s_r.timing[cfb_pkg::TIM_PSC_LSB +: 16];
  assign tif.busOff = (s_r.state == cfb_pkg::ST_BUSOFF);
  assign tif.rxSync = s_r.rx2;

  cfb_bit_timing_unit u_btu (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .tif(tif)
  );

  always_comb begin
    s_nxt = s_r;
    s_nxt.rx1 = canRx;
    s_nxt.rx2 = s_r.rx1;
    s_nxt.samp = tif.samplePulse;
    s_nxt.sampB = tif.sampleBit;
    s_nxt.txPt = tif.txPointPulse;
    // Dominant run watch after an error or overload flag
    stepDom = 1'b0;
    if (evFlagEnd) begin
      s_nxt.watchDom = 1'b1;
      s_nxt.domCnt = 4'h0;
      s_nxt.domFirstDone = 1'b0;
      s_nxt.domPassiveRule = flagWasPassive;
    end else if (s_r.watchDom && tif.samplePulse) begin
      if (tif.sampleBit) begin
        s_nxt.watchDom = 1'b0;
      end else begin
        s_nxt.domCnt = s_r.domCnt + 4'h1;
        if (!s_r.domFirstDone && s_r.domCnt + 4'h1 ==
            (s_r.domPassiveRule ? cfb_pkg::FIRST_DOM_PASSIVE : cfb_pkg::FIRST_DOM_ACTIVE)) begin
          stepDom = 1'b1;
          s_nxt.domFirstDone = 1'b1;
          s_nxt.domCnt = 4'h0;
        end else if (s_r.domFirstDone && s_r.domCnt + 4'h1 == cfb_pkg::DOM_REPEAT) begin
          stepDom = 1'b1;
          s_nxt.domCnt = 4'h0;
        end
      end
    end
    // Track dominant bits seen while a passive flag is out
    if (errFlagReq && tif.samplePulse && !tif.sampleBit) begin
      s_nxt.passiveSawDom = 1'b1;
    end else if (!errFlagReq) begin
      s_nxt.passiveSawDom = 1'b0;
    end
    recBig = evRxFlagBitErr || evRxDomAfterFlag || (stepDom && !isTransmitter);
    recOne = evOtherErr && !isTransmitter;
    tecBig = evTxFlagBitErr || (stepDom && isTransmitter) ||
             (evOtherErr && isTransmitter && !evArbStuffErr &&
              !(evAckErr && s_r.state == cfb_pkg::ST_PASSIVE && !s_r.passiveSawDom));
    recDec = evRxOk && s_r.rx_error_count != 8'h00;
    tecDec = evTxOk && s_r.tx_error_count != 8'h00;
    recSum = {1'b0, s_r.rx_error_count};
    if (recBig || recOne) begin
      if (!s_r.rx_error_count[7]) begin
        recSum = {1'b0, s_r.rx_error_count} + (recBig ? {1'b0, cfb_pkg::BIG_STEP} : 9'h001);
      end
    end else if (recDec) begin
      recSum = {1'b0, s_r.rx_error_count} - 9'h001;
    end
    tecSum = {1'b0, s_r.tx_error_count};
    if (tecBig) begin
      tecSum = {1'b0, s_r.tx_error_count} + {1'b0, cfb_pkg::BIG_STEP};
    end else if (tecDec) begin
      tecSum = {1'b0, s_r.tx_error_count} - 9'h001;
    end
    if (s_r.state != cfb_pkg::ST_BUSOFF && s_r.state != cfb_pkg::ST_SYNC) begin
      s_nxt.rx_error_count = recSum[8] ? 8'hFF : recSum[7:0];
      s_nxt.tx_error_count = tecSum[8] ? 8'hFF : tecSum[7:0];
    end
    // Recessive run counter on sampled bits
    if (tif.samplePulse) begin
      s_nxt.recRun = (tif.sampleBit && s_r.recRun != cfb_pkg::RECESSIVE_RUN) ?
                     s_r.recRun + 4'h1 : (tif.sampleBit ? s_r.recRun : 4'h0);
      if (s_r.state == cfb_pkg::ST_BUSOFF && tif.sampleBit) begin
        s_nxt.recRun = (s_r.recRun + 4'h1 == cfb_pkg::RECESSIVE_RUN) ? 4'h0 : s_r.recRun + 4'h1;
      end
    end
    case (s_r.state)
      cfb_pkg::ST_SYNC: begin
        if (s_r.enable && tif.samplePulse && tif.sampleBit &&
            s_r.recRun + 4'h1 >= cfb_pkg::RECESSIVE_RUN) begin
          s_nxt.state = cfb_pkg::ST_ACTIVE;
        end
      end
      cfb_pkg::ST_ACTIVE, cfb_pkg::ST_WARNING, cfb_pkg::ST_PASSIVE: begin
        if (tecSum > cfb_pkg::BUSOFF_LIMIT) begin
          s_nxt.state = cfb_pkg::ST_BUSOFF;
          s_nxt.runCnt = 8'h00;
          // Recessive bits seen before bus off must not shorten the first run
          s_nxt.recRun = 4'h0;
        end else if ({1'b0, s_nxt.tx_error_count} > cfb_pkg::PASSIVE_LIMIT ||
                     {1'b0, s_nxt.rx_error_count} > cfb_pkg::PASSIVE_LIMIT) begin
          s_nxt.state = cfb_pkg::ST_PASSIVE;
        end else if ({1'b0, s_nxt.tx_error_count} >= cfb_pkg::WARN_LIMIT ||
                     {1'b0, s_nxt.rx_error_count} >= cfb_pkg::WARN_LIMIT) begin
          s_nxt.state = cfb_pkg::ST_WARNING;
        end else begin
          s_nxt.state = cfb_pkg::ST_ACTIVE;
        end
      end
      cfb_pkg::ST_BUSOFF: begin
        if (tif.samplePulse && tif.sampleBit && s_r.recRun + 4'h1 == cfb_pkg::RECESSIVE_RUN) begin
          s_nxt.runCnt = s_r.runCnt + 8'h01;
          if (s_r.runCnt + 8'h01 == cfb_pkg::RECOVERY_RUNS) begin
            s_nxt.state = cfb_pkg::ST_ACTIVE;
            s_nxt.rx_error_count = 8'h00;
            s_nxt.tx_error_count = 8'h00;
          end
        end
      end
      default: s_nxt.state = cfb_pkg::ST_SYNC;
    endcase
    if (!s_r.enable) begin
      s_nxt.state = cfb_pkg::ST_SYNC;
      // Idle bits only count once the node is enabled
      s_nxt.recRun = 4'h0;
    end
    // Pin drive: dominant flag only when active-type state
    s_nxt.tx = 1'b1;
    s_nxt.txEn = 1'b0;
    if (s_r.state != cfb_pkg::ST_BUSOFF && s_r.state != cfb_pkg::ST_SYNC) begin
      if (errFlagReq && s_r.state != cfb_pkg::ST_PASSIVE) begin
        s_nxt.tx = 1'b0;
        s_nxt.txEn = 1'b1;
      end else if (errFlagReq) begin
        s_nxt.tx = 1'b1;
      end else if (!flagDominant) begin
        s_nxt.tx = 1'b1;
      end else begin
        s_nxt.tx = 1'b0;
        s_nxt.txEn = 1'b1;
      end
    end
    // Avalon slave: one wait cycle, answer on the second
    access = (avs_read || avs_write) && s_r.wait_n == 1'b0;
    s_nxt.wait_n = 1'b0;
    if (access) begin
      s_nxt.wait_n = 1'b1;
      s_nxt.rdata = 32'h0000_0000;
      case (avs_address)
        cfb_pkg::OFS_ERR_PAIR: s_nxt.rdata = {16'h0000, s_r.tx_error_count, s_r.rx_error_count};
        cfb_pkg::OFS_STATE: s_nxt.rdata = {29'h0000_0000, s_r.state};
        cfb_pkg::OFS_TIMING: s_nxt.rdata = s_r.timing;
        cfb_pkg::OFS_CTRL: s_nxt.rdata = {31'h0000_0000, s_r.enable};
        default: s_nxt.rdata = 32'h0000_0000;
      endcase
    end
    // Write commits on the answer cycle, where the master samples waitrequest low
    if (avs_write && s_r.wait_n) begin
      if (avs_address == cfb_pkg::OFS_TIMING) begin
        for (int b = 0; b < 4; b++) begin
          if (avs_byteenable[b]) begin
            s_nxt.timing[b*8 +: 8] = avs_writedata[b*8 +: 8];
          end
        end
      end else if (avs_address == cfb_pkg::OFS_CTRL && avs_byteenable[0]) begin
        s_nxt.enable = avs_writedata[0];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '{rx1: 1'b1, rx2: 1'b1, rx_error_count: 8'h00, tx_error_count: 8'h00, state: cfb_pkg::ST_SYNC,
               recRun: 4'h0, runCnt: 8'h00, watchDom: 1'b0, domCnt: 4'h0, domFirstDone: 1'b0,
               domPassiveRule: 1'b0, passiveSawDom: 1'b0, timing: cfb_pkg::TIM_RESET,
               enable: 1'b0, rdata: 32'h0000_0000, wait_n: 1'b0, tx: 1'b1, txEn: 1'b0,
               samp: 1'b0, sampB: 1'b1, txPt: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign avs_readdata = s_r.rdata;
  assign avs_waitrequest = !s_r.wait_n;
  assign canTx = s_r.tx;
  assign canTxEn = s_r.txEn;
  assign nodeState = s_r.state;
  assign samplePulse = s_r.samp;
  assign sampleBit = s_r.sampB;
  assign txPoint = s_r.txPt;
endmodule

// ### verification/cfb_fault_confinement_asserts.sv
// Concurrent checks on the fault confinement top ports
`timescale 1ns/1ps
module cfb_fault_confinement_asserts (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register bus
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Bus pins and status
  input wire logic canTxEn,
  input wire logic errFlagReq,
  input wire logic [2:0] nodeState,
  input wire logic samplePulse,
  input wire logic sampleBit,
  input wire logic txPoint
);
  logic [11:0] recSamples_r;
  logic [11:0] recSamples_nxt;
  logic sitsOut;
  // Recessive samples while the node sits out; cleared once it rejoins
  assign sitsOut = nodeState == 3'h0 || nodeState == 3'h4;
  assign recSamples_nxt = sitsOut ? recSamples_r + {11'h000, samplePulse & sampleBit} : 12'h000;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      recSamples_r <= 12'h000;
    end else begin
      recSamples_r <= recSamples_nxt;
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  property p_answer;
    $rose(avs_read) || $rose(avs_write) |->
      avs_waitrequest ##1 !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_answer: assert property (p_answer) else $error("bus answer timing wrong");
  property p_pair;
    avs_read && !avs_waitrequest && avs_address == cfb_pkg::OFS_ERR_PAIR |->
      avs_readdata[31:16] == 16'h0000;
  endproperty
  a_pair: assert property (p_pair) else $error("error pair upper half set");
  property p_state_read;
    avs_read && !avs_waitrequest && avs_address == cfb_pkg::OFS_STATE |->
      avs_readdata[31:3] == 29'h0 && avs_readdata[2:0] <= 3'h4;
  endproperty
  a_state_read: assert property (p_state_read) else $error("state read bad");
  property p_entry; nodeState == 3'h4 && $past(nodeState) != 3'h4 |-> $past(nodeState) == 3'h3; endproperty
  a_entry: assert property (p_entry) else $error("bus off not from passive");
  property p_quiet; nodeState == 3'h4 && $past(nodeState) == 3'h4 |-> !canTxEn; endproperty
  a_quiet: assert property (p_quiet) else $error("driver on in bus off");
  property p_passive_flag; $rose(canTxEn) |-> !($past(errFlagReq) && $past(nodeState) == 3'h3); endproperty
  a_passive_flag: assert property (p_passive_flag) else $error("dominant flag while passive");
  property p_recover;
    $past(nodeState) == 3'h4 && nodeState != 3'h4 |-> nodeState == 3'h1 && recSamples_r >= 12'h57F;
  endproperty
  a_recover: assert property (p_recover) else $error("bus off left too early");
  property p_join;
    $past(nodeState) == 3'h0 && nodeState != 3'h0 |-> nodeState == 3'h1 && recSamples_r >= 12'h00A;
  endproperty
  a_join: assert property (p_join) else $error("joined before idle bits");
  property p_spacing; samplePulse |=> !samplePulse [*2]; endproperty
  a_spacing: assert property (p_spacing) else $error("sample points too close");
  property p_order; txPoint |-> !samplePulse; endproperty
  a_order: assert property (p_order) else $error("sample and send point together");
  c_warning: cover property (nodeState == 3'h2);
  c_passive: cover property (nodeState == 3'h3);
  c_busoff: cover property (nodeState == 3'h4);
endmodule
bind cfb_fault_confinement cfb_fault_confinement_asserts u_asserts (
  .ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .canTxEn(canTxEn), .errFlagReq(errFlagReq), .nodeState(nodeState),
  .samplePulse(samplePulse), .sampleBit(sampleBit), .txPoint(txPoint)
);

// ### verification/cfb_bus_node.sv
// Model of the other nodes sharing the bus, wired-AND with the device
`timescale 1ns/1ps
module cfb_bus_node (
  // Pacing clock
  input wire logic ref_clk,
  // Device driver
  input wire logic canTx,
  input wire logic canTxEn,
  // Resolved bus level
  output logic canRx
);
  logic othersDom;
  initial othersDom = 1'b0;
  // Termination pulls the bus recessive whenever no node drives it
  assign canRx = !(othersDom || (canTxEn && !canTx));
  // Another node drives dominant for some clocks, then lets go
  task automatic dominant(input int clocks);
    othersDom <= 1'b1;
    repeat (clocks) @(posedge ref_clk);
    othersDom <= 1'b0;
  endtask
endmodule

// ### verification/cfb_fault_confinement_bench.sv
// Self-checking bench for the CAN fault confinement and bit timing block
`timescale 1ns/1ps
module cfb_fault_confinement_bench;
  localparam logic [8:0] RXFLAG = 9'h001, RXDOM = 9'h002, TXFLAG = 9'h004, OTHER = 9'h008;
  localparam logic [8:0] ARB = 9'h010, ACK = 9'h020, FEND = 9'h040, TXOK = 9'h100;
  logic ref_clk, rst_n, read, write, waitrequest, canRx, canTx, canTxEn;
  logic errFlagReq, flagDominant, isTransmitter, flagWasPassive, samplePulse, sampleBit, txPoint;
  logic [3:0] address;
  logic [31:0] writedata, readdata, rd;
  logic [8:0] ev;
  logic [2:0] nodeState;
  int failures, checkCount, n;
  logic [3:0] regAddr [5] = '{4'h0, 4'h4, 4'h8, 4'hC, 4'h1};
  logic [31:0] regExp [5] = '{32'h0, 32'h0, cfb_pkg::TIM_RESET, 32'h0, 32'h0};

  cfb_fault_confinement u_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .avs_address(address), .avs_read(read),
    .avs_write(write), .avs_writedata(writedata), .avs_byteenable(4'hF),
    .avs_readdata(readdata), .avs_waitrequest(waitrequest), .canRx(canRx), .canTx(canTx),
    .canTxEn(canTxEn), .errFlagReq(errFlagReq), .flagDominant(flagDominant),
    .isTransmitter(isTransmitter), .evRxFlagBitErr(ev[0]), .evRxDomAfterFlag(ev[1]),
    .evTxFlagBitErr(ev[2]), .evOtherErr(ev[3]), .evArbStuffErr(ev[4]), .evAckErr(ev[5]),
    .evFlagEnd(ev[6]), .flagWasPassive(flagWasPassive), .evRxOk(ev[7]), .evTxOk(ev[8]),
    .nodeState(nodeState), .samplePulse(samplePulse), .sampleBit(sampleBit), .txPoint(txPoint)
  );
  cfb_bus_node u_node (.ref_clk(ref_clk), .canTx(canTx), .canTxEn(canTxEn), .canRx(canRx));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", checkCount, failures);
    if (failures == 0 && checkCount > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checkCount++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Holds the request until waitrequest is sampled low, then lets one edge pass
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    int k;
    k = 0;
    address <= a;
    writedata <= wd;
    read <= !wr;
    write <= wr;
    do begin
      @(posedge ref_clk);
      k++;
    end while (waitrequest !== 1'b0 && k < 50);
    if (waitrequest !== 1'b0) begin
      failures++;
      conclude();
    end
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic hit(input logic [8:0] m, input logic tx, input int times);
    repeat (times) begin
      isTransmitter <= tx;
      ev <= m;
      @(posedge ref_clk);
      ev <= 9'h000;
      @(posedge ref_clk);
    end
  endtask

  task automatic chk(input logic [7:0] t, input logic [7:0] r, input logic [2:0] s);
    bus(1'b0, cfb_pkg::OFS_ERR_PAIR, 32'h0);
    check("error pair", {16'h0000, t, r}, rd);
    bus(1'b0, cfb_pkg::OFS_STATE, 32'h0);
    check("state reg", {29'h0, s}, rd);
    check("state port", {29'h0, s}, {29'h0, nodeState});
  endtask

  task automatic waitState(input logic [2:0] s, input int lim);
    n = 0;
    while (nodeState !== s && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
    if (nodeState !== s) begin
      failures++;
      conclude();
    end
  endtask

  task automatic waitSample(input int lim);
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (samplePulse !== 1'b1 && n < lim);
    if (samplePulse !== 1'b1) begin
      failures++;
      conclude();
    end
  endtask

  initial begin
    rst_n = 1'b0;
    {read, write, errFlagReq, flagDominant, isTransmitter, flagWasPassive} = 6'h00;
    address = 4'h0;
    writedata = 32'h0;
    ev = 9'h000;
    failures = 0;
    checkCount = 0;
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, regAddr[i], 32'h0);
      check("reset value", regExp[i], rd);
    end
    bus(1'b1, cfb_pkg::OFS_ERR_PAIR, 32'hFFFF_FFFF);
    bus(1'b1, 4'h1, 32'hFFFF_FFFF);
    chk(8'h00, 8'h00, 3'h0);
    bus(1'b1, cfb_pkg::OFS_CTRL, 32'h0000_0001);
    waitState(3'h1, 400);
    check("clocks to join", 32'h1, 32'(n >= 72));
    hit(OTHER, 1'b1, 11);
    hit(TXFLAG, 1'b1, 1);
    chk(8'h60, 8'h00, 3'h2);
    hit(TXOK, 1'b1, 1);
    chk(8'h5F, 8'h00, 3'h1);
    hit(OTHER, 1'b1, 5);
    chk(8'h87, 8'h00, 3'h3);
    errFlagReq <= 1'b1;
    flagDominant <= 1'b1;
    flagWasPassive <= 1'b1;
    hit(OTHER | ARB, 1'b1, 1);
    hit(OTHER | ACK, 1'b1, 1);
    repeat (24) @(posedge ref_clk);
    hit(FEND, 1'b1, 1);
    check("passive driver", 32'h0, {31'h0, canTxEn});
    {errFlagReq, flagDominant, flagWasPassive} <= 3'h0;
    chk(8'h87, 8'h00, 3'h3);
    hit(TXOK, 1'b1, 8);
    chk(8'h7F, 8'h00, 3'h2);
    flagDominant <= 1'b1;
    repeat (24) @(posedge ref_clk);
    check("driven bus", 32'h0, {31'h0, canRx});
    flagDominant <= 1'b0;
    repeat (24) @(posedge ref_clk);
    hit(OTHER, 1'b0, 1);
    hit(RXFLAG, 1'b0, 8);
    hit(RXDOM, 1'b0, 8);
    chk(8'h7F, 8'h81, 3'h3);
    hit(OTHER, 1'b0, 1);
    hit(RXFLAG, 1'b0, 1);
    chk(8'h7F, 8'h81, 3'h3);
    hit(OTHER, 1'b1, 16);
    chk(8'hFF, 8'h81, 3'h3);
    hit(OTHER, 1'b1, 2);
    chk(8'hFF, 8'h81, 3'h4);
    waitState(3'h1, 13000);
    check("recovery clocks", 32'h1, 32'(n >= 11200));
    chk(8'h00, 8'h00, 3'h1);
    // Jump width kept within both segments, as software must
    bus(1'b1, cfb_pkg::OFS_TIMING, 32'h0002_0235);
    bus(1'b0, cfb_pkg::OFS_TIMING, 32'h0);
    check("timing reg", 32'h0002_0235, rd);
    waitSample(60);
    waitSample(60);
    waitSample(60);
    check("bit clocks", 32'h12, n);
    fork
      u_node.dominant(54);
    join_none
    repeat (4) @(posedge ref_clk);
    waitSample(40);
    check("sampled level", 32'h0, {31'h0, sampleBit});
    repeat (80) @(posedge ref_clk);
    // Dominant run after an active flag: 16 or 17 dominant samples give one step
    fork
      u_node.dominant(300);
    join_none
    repeat (4) @(posedge ref_clk);
    hit(FEND, 1'b0, 1);
    repeat (310) @(posedge ref_clk);
    chk(8'h00, 8'h08, 3'h1);
    conclude();
  end
endmodule
